// File: inc/timer16_params.svh
// constants for the 16-bit timer/counter control block
// assumes an 8-bit I/O register space with 6-bit byte addresses
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_CAPT_L 6'h22
`define OFS_CAPT_H 6'h23
`define OFS_CMPB_L 6'h24
`define OFS_CMPB_H 6'h25
`define OFS_CMPA_L 6'h26
`define OFS_CMPA_H 6'h27
`define OFS_CNT_L 6'h28
`define OFS_CNT_H 6'h29
`define OFS_FORCE 6'h2c
`define OFS_CTRL_B 6'h2d
`define OFS_CTRL_A 6'h2e

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRLA_COMA_HI 7
`define CTRLA_COMA_LO 6
`define CTRLA_COMB_HI 5
`define CTRLA_COMB_LO 4
`define CTRLA_WGM_HI 1
`define CTRLA_WGM_LO 0
`define CTRLB_FILT_BIT 7
`define CTRLB_EDGE_BIT 6
`define CTRLB_WGM_HI 4
`define CTRLB_WGM_LO 3
`define CTRLB_CS_HI 2
`define CTRLB_CS_LO 0
`define FORCE_A_BIT 7
`define FORCE_B_BIT 6

// ----------------------------------------------------------------------
// reset values and fixed tops
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define TOP_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define FILTER_SAMPLES 4
`define PRE_BITS 10
`define PRE_DIV8_MASK 10'h007
`define PRE_DIV64_MASK 10'h03f
`define PRE_DIV256_MASK 10'h0ff
`define PRE_DIV1024_MASK 10'h3ff

`endif

// File: inc/timer16_pkg.sv
// types shared by the timer/counter control block
// constants live in timer16_params.svh
package timer16_pkg;

  typedef enum logic [2:0] {
    CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
    CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } clock_sel_type;

  typedef enum logic [2:0] {
    KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PHASE, KIND_PFC
  } wave_kind_type;

  typedef enum logic [1:0] {
    TOP_FIXED, TOP_CMPA, TOP_CAPT
  } top_src_type;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } io_req_type;

  typedef struct packed {
    logic overflow;
    logic match_a;
    logic match_b;
    logic capture;
  } timer_events_type;

endpackage : timer16_pkg

// File: logic/timer16_prescaler.sv
// timer clock enable: prescaled core clock or external count pin
// assumes ext_count_pin is asynchronous to core_clk
`timescale 1ns/10ps
`include "timer16_params.svh"

module timer16_prescaler (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [2:0] clock_source_sel,
  input wire logic ext_count_pin,
  output logic tick
);
  import timer16_pkg::*;

  logic [`PRE_BITS-1:0] pre_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_last_reg;
  logic tick_reg;
  logic rise;
  logic fall;
  logic tick_next;
  clock_sel_type sel;

  assign sel = clock_sel_type'(clock_source_sel);
  // the pin is sampled whatever its port direction, so software can
  // drive it as an output and still clock the counter
  assign rise = ext_sync_reg & ~ext_last_reg;
  assign fall = ~ext_sync_reg & ext_last_reg;
  assign tick = tick_reg;

  always_comb begin
    case (sel)
      CS_STOP: tick_next = 1'b0;
      CS_DIV1: tick_next = 1'b1;
      CS_DIV8: tick_next = (pre_reg & `PRE_DIV8_MASK) == `PRE_DIV8_MASK;
      CS_DIV64: tick_next = (pre_reg & `PRE_DIV64_MASK) == `PRE_DIV64_MASK;
      CS_DIV256: begin
        tick_next = (pre_reg & `PRE_DIV256_MASK) == `PRE_DIV256_MASK;
      end
      CS_DIV1024: tick_next = pre_reg == `PRE_DIV1024_MASK;
      CS_EXT_FALL: tick_next = fall;
      CS_EXT_RISE: tick_next = rise;
      default: tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_last_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      ext_meta_reg <= ext_count_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_last_reg <= ext_sync_reg;
      tick_reg <= tick_next;
    end
  end

endmodule : timer16_prescaler

// File: logic/timer16_capture_in.sv
// capture pin conditioning: synchroniser, optional filter, edge pick
// assumes capture_input_pin is asynchronous to core_clk
`timescale 1ns/10ps
`include "timer16_params.svh"

module timer16_capture_in (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic capture_input_pin,
  input wire logic capture_filter_en,
  input wire logic capture_edge_sel,
  input wire logic capture_enable,
  output logic trig
);
  import timer16_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic [`FILTER_SAMPLES-2:0] hist_reg;
  logic filt_reg;
  logic last_reg;
  logic trig_reg;
  logic level;
  logic all_one;
  logic all_zero;

  // the live sample is the fourth of the run, so the filter adds
  // exactly four cycles of delay, not five
  assign all_one = &{hist_reg, sync_reg};
  assign all_zero = ~|{hist_reg, sync_reg};
  assign level = capture_filter_en ? filt_reg : sync_reg;
  assign trig = trig_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      hist_reg <= '0;
      filt_reg <= 1'b0;
      last_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      meta_reg <= capture_input_pin;
      sync_reg <= meta_reg;
      hist_reg <= {hist_reg[`FILTER_SAMPLES-3:0], sync_reg};
      if (all_one || all_zero) begin
        filt_reg <= sync_reg;
      end
      last_reg <= level;
      // edge select 0 picks falling, 1 picks rising
      trig_reg <= capture_enable & (level ^ last_reg) &
                  (level == capture_edge_sel);
    end
  end

endmodule : timer16_capture_in

// File: logic/timer16_mode_clock_capture_ctrl.sv
// 16-bit timer/counter: modes, clock select, capture, force, 16-bit access
// assumes a core that issues one-cycle io writes and reads on core_clk;
// read data appear on io_rdata one cycle after the read strobe
`timescale 1ns/10ps
`include "timer16_params.svh"

module timer16_mode_clock_capture_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire timer16_pkg::io_req_type io_req,
  output logic [7:0] io_rdata,
  input wire logic capture_input_pin,
  input wire logic ext_count_pin,
  output logic compare_out_a,
  output logic compare_out_b,
  output timer16_pkg::timer_events_type events
);
  import timer16_pkg::*;

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] temp_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] capt_reg;
  logic up_reg;
  logic block_reg;
  logic [7:0] rdata_reg;
  timer_events_type events_reg;
  timer_events_type events_next;

  logic [3:0] waveform_mode_sel;
  logic [2:0] clock_source_sel;
  logic capture_filter_en;
  logic capture_edge_sel;
  wave_kind_type kind;
  top_src_type top_src;
  logic [15:0] fixed_top;
  logic [15:0] top_value;
  logic tick;
  logic capt_trig;
  logic capt_enable;
  logic at_top;
  logic at_bottom;
  logic pwm_mode;
  logic flag_at_top_max;

  // register decode
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_force;
  logic wr_cnt_l;
  logic wr_capt_l;
  logic wr_high;
  logic rd_cnt_l;
  logic rd_capt_l;
  logic [1:0] force_strobe;

  assign wr_ctrl_a = io_req.wr && io_req.addr == `OFS_CTRL_A;
  assign wr_ctrl_b = io_req.wr && io_req.addr == `OFS_CTRL_B;
  assign wr_force = io_req.wr && io_req.addr == `OFS_FORCE;
  assign wr_cnt_l = io_req.wr && io_req.addr == `OFS_CNT_L;
  assign wr_capt_l = io_req.wr && io_req.addr == `OFS_CAPT_L;
  assign wr_high = io_req.wr && (io_req.addr == `OFS_CNT_H ||
                   io_req.addr == `OFS_CMPA_H ||
                   io_req.addr == `OFS_CMPB_H ||
                   io_req.addr == `OFS_CAPT_H);
  assign rd_cnt_l = io_req.rd && io_req.addr == `OFS_CNT_L;
  assign rd_capt_l = io_req.rd && io_req.addr == `OFS_CAPT_L;

  assign waveform_mode_sel = {ctrl_b_reg[`CTRLB_WGM_HI:`CTRLB_WGM_LO],
                              ctrl_a_reg[`CTRLA_WGM_HI:`CTRLA_WGM_LO]};
  assign clock_source_sel = ctrl_b_reg[`CTRLB_CS_HI:`CTRLB_CS_LO];
  assign capture_filter_en = ctrl_b_reg[`CTRLB_FILT_BIT];
  assign capture_edge_sel = ctrl_b_reg[`CTRLB_EDGE_BIT];

  // --------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------
  // the reserved code 1101 falls to plain counting so the counter never
  // locks up if software writes it by mistake
  always_comb begin
    kind = KIND_NORMAL;
    top_src = TOP_FIXED;
    fixed_top = `TOP_MAX;
    case (waveform_mode_sel)
      4'h0: kind = KIND_NORMAL;
      4'h1: begin
        kind = KIND_PHASE;
        fixed_top = `TOP_8BIT;
      end
      4'h2: begin
        kind = KIND_PHASE;
        fixed_top = `TOP_9BIT;
      end
      4'h3: begin
        kind = KIND_PHASE;
        fixed_top = `TOP_10BIT;
      end
      4'h4: begin
        kind = KIND_CTC;
        top_src = TOP_CMPA;
      end
      4'h5: begin
        kind = KIND_FAST;
        fixed_top = `TOP_8BIT;
      end
      4'h6: begin
        kind = KIND_FAST;
        fixed_top = `TOP_9BIT;
      end
      4'h7: begin
        kind = KIND_FAST;
        fixed_top = `TOP_10BIT;
      end
      4'h8: begin
        kind = KIND_PFC;
        top_src = TOP_CAPT;
      end
      4'h9: begin
        kind = KIND_PFC;
        top_src = TOP_CMPA;
      end
      4'ha: begin
        kind = KIND_PHASE;
        top_src = TOP_CAPT;
      end
      4'hb: begin
        kind = KIND_PHASE;
        top_src = TOP_CMPA;
      end
      4'hc: begin
        kind = KIND_CTC;
        top_src = TOP_CAPT;
      end
      4'he: begin
        kind = KIND_FAST;
        top_src = TOP_CAPT;
      end
      4'hf: begin
        kind = KIND_FAST;
        top_src = TOP_CMPA;
      end
      default: kind = KIND_NORMAL;
    endcase
  end

  assign pwm_mode = kind == KIND_FAST || kind == KIND_PHASE ||
                    kind == KIND_PFC;
  assign capt_enable = top_src != TOP_CAPT;
  assign at_bottom = cnt_reg == `RST_WORD;
  assign at_top = cnt_reg == top_value;
  assign flag_at_top_max = kind == KIND_NORMAL || kind == KIND_CTC;

  // --------------------------------------------------------------------
  // clock source and capture pin
  // --------------------------------------------------------------------
  timer16_prescaler u_prescaler (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clock_source_sel(clock_source_sel),
    .ext_count_pin(ext_count_pin),
    .tick(tick)
  );

  timer16_capture_in u_capture_in (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .capture_input_pin(capture_input_pin),
    .capture_filter_en(capture_filter_en),
    .capture_edge_sel(capture_edge_sel),
    .capture_enable(capt_enable),
    .trig(capt_trig)
  );

  // --------------------------------------------------------------------
  // compare channels
  // --------------------------------------------------------------------
  logic [15:0] cmp_buf [2];
  logic [15:0] cmp_act [2];
  logic [1:0] match;
  logic [1:0] wave_out;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      logic [15:0] buf_reg;
      logic [15:0] act_reg;
      logic out_reg;
      logic [1:0] com;
      logic wr_low;
      logic load;
      logic hit;
      logic set_val;
      logic out_next;

      assign com = (ch == 0) ?
        ctrl_a_reg[`CTRLA_COMA_HI:`CTRLA_COMA_LO] :
        ctrl_a_reg[`CTRLA_COMB_HI:`CTRLA_COMB_LO];
      assign wr_low = io_req.wr && io_req.addr ==
        ((ch == 0) ? `OFS_CMPA_L : `OFS_CMPB_L);
      // double buffer: immediate modes see the written value at once
      assign load = (kind == KIND_NORMAL || kind == KIND_CTC) ||
                    (tick && at_top && (kind == KIND_FAST ||
                     kind == KIND_PHASE)) ||
                    (tick && at_bottom && kind == KIND_PFC);
      // a counter write suppresses the match on the next timer clock
      assign hit = tick && !block_reg &&
                   cnt_reg == act_reg;
      assign force_strobe[ch] = wr_force && !pwm_mode &&
        io_req.wdata[(ch == 0) ? `FORCE_A_BIT : `FORCE_B_BIT];
      assign set_val = (kind == KIND_PHASE || kind == KIND_PFC) ?
                       (com[0] ~^ up_reg) : com[0];

      always_comb begin
        out_next = out_reg;
        if (!pwm_mode) begin
          if (hit || force_strobe[ch]) begin
            case (com)
              2'b01: out_next = ~out_reg;
              2'b10: out_next = 1'b0;
              2'b11: out_next = 1'b1;
              default: out_next = out_reg;
            endcase
          end
        end else if (com == 2'b01) begin
          if (hit && ch == 0 && waveform_mode_sel[3]) begin
            out_next = ~out_reg;
          end
        end else if (com[1]) begin
          if (hit) begin
            out_next = set_val;
          end else if (tick && at_top && kind == KIND_FAST) begin
            out_next = ~com[0];
          end
        end
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          buf_reg <= `RST_WORD;
          act_reg <= `RST_WORD;
          out_reg <= 1'b0;
        end else begin
          if (wr_low) begin
            buf_reg <= {temp_reg, io_req.wdata};
          end
          if (load) begin
            act_reg <= wr_low ? {temp_reg, io_req.wdata} : buf_reg;
          end
          out_reg <= out_next;
        end
      end

      assign cmp_buf[ch] = buf_reg;
      assign cmp_act[ch] = act_reg;
      assign match[ch] = hit;
      assign wave_out[ch] = out_reg;
    end
  endgenerate

  assign top_value = (top_src == TOP_CMPA) ? cmp_act[0] :
                     (top_src == TOP_CAPT) ? capt_reg : fixed_top;

  // --------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------
  // ctc clears by reaching top, not by a match event, so a forced
  // strobe cannot clear the timer
  always_comb begin
    cnt_next = cnt_reg;
    if (wr_cnt_l) begin
      cnt_next = {temp_reg, io_req.wdata};
    end else if (tick) begin
      if (kind == KIND_PHASE || kind == KIND_PFC) begin
        if ((up_reg && !at_top) || at_bottom) begin
          cnt_next = cnt_reg + 16'h0001;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end else if (at_top) begin
        cnt_next = `RST_WORD;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // events towards the flag register
  // --------------------------------------------------------------------
  always_comb begin
    events_next.overflow = 1'b0;
    if (tick) begin
      if (flag_at_top_max) begin
        events_next.overflow = cnt_reg == `TOP_MAX;
      end else if (kind == KIND_FAST) begin
        events_next.overflow = at_top;
      end else begin
        events_next.overflow = at_bottom && !up_reg;
      end
    end
    // forced strobes never reach the match events
    events_next.match_a = match[0];
    events_next.match_b = match[1];
    events_next.capture = (capt_trig && capt_enable) ||
                          (!capt_enable && tick && at_top);
  end

  // --------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (io_req.addr)
      `OFS_CTRL_A: rd_mux = ctrl_a_reg & 8'hf3;
      `OFS_CTRL_B: rd_mux = ctrl_b_reg & 8'hdf;
      `OFS_FORCE: rd_mux = `RST_BYTE;
      `OFS_CNT_L: rd_mux = cnt_reg[7:0];
      `OFS_CNT_H: rd_mux = temp_reg;
      `OFS_CAPT_L: rd_mux = capt_reg[7:0];
      `OFS_CAPT_H: rd_mux = temp_reg;
      // compare registers are read directly, without the latch
      `OFS_CMPA_L: rd_mux = cmp_buf[0][7:0];
      `OFS_CMPA_H: rd_mux = cmp_buf[0][15:8];
      `OFS_CMPB_L: rd_mux = cmp_buf[1][7:0];
      `OFS_CMPB_H: rd_mux = cmp_buf[1][15:8];
      default: rd_mux = `RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_reg <= `RST_BYTE;
      ctrl_b_reg <= `RST_BYTE;
      temp_reg <= `RST_BYTE;
      rdata_reg <= `RST_BYTE;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_reg <= io_req.wdata & 8'hf3;
      end
      if (wr_ctrl_b) begin
        ctrl_b_reg <= io_req.wdata & 8'hdf;
      end
      if (wr_high) begin
        temp_reg <= io_req.wdata;
      end else if (rd_cnt_l) begin
        temp_reg <= cnt_reg[15:8];
      end else if (rd_capt_l) begin
        temp_reg <= capt_reg[15:8];
      end
      if (io_req.rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= `RST_WORD;
      up_reg <= 1'b1;
      block_reg <= 1'b0;
      capt_reg <= `RST_WORD;
      events_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      if (tick && (at_top || at_bottom)) begin
        up_reg <= at_bottom;
      end
      if (wr_cnt_l) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
      if (wr_capt_l) begin
        capt_reg <= {temp_reg, io_req.wdata};
      end else if (capt_trig && capt_enable) begin
        capt_reg <= cnt_reg;
      end
      events_reg <= events_next;
    end
  end

  assign io_rdata = rdata_reg;
  assign compare_out_a = wave_out[0];
  assign compare_out_b = wave_out[1];
  assign events = events_reg;

endmodule : timer16_mode_clock_capture_ctrl

// File: tb/timer16_monitor.sv
// checker on the timer top ports
// assumes control writes are visible on io_req
`timescale 1ns/10ps
`include "timer16_params.svh"
module timer16_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire timer16_pkg::io_req_type io_req,
  input wire logic [7:0] io_rdata,
  input wire logic capture_input_pin,
  input wire logic compare_out_a,
  input wire timer16_pkg::timer_events_type events
);
  import timer16_pkg::*;
  logic [7:0] cta_reg, ctb_reg;
  wire logic [3:0] mode = {ctb_reg[4:3], cta_reg[1:0]};
  wire logic [2:0] cs = ctb_reg[2:0];
  // modes 8,10,12,14 take capture as top
  wire logic cap_on = !(mode[3] && !mode[0]);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cta_reg <= 8'h00;
      ctb_reg <= 8'h00;
    end else if (io_req.wr) begin
      if (io_req.addr == `OFS_CTRL_A) cta_reg <= io_req.wdata;
      if (io_req.addr == `OFS_CTRL_B) ctb_reg <= io_req.wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence rd_at(a);
    io_req.rd && io_req.addr == a;
  endsequence
  sequence frc_a;
    io_req.wr && io_req.addr == `OFS_FORCE && io_req.wdata[7] && cs == 0;
  endsequence
  force_zero_a: assert property (
    rd_at(`OFS_FORCE) |=> io_rdata == 8'h00) else $error("force read");
  rdata_hold_a: assert property (
    !io_req.rd |=> $stable(io_rdata)) else $error("read data moved");
  stop_quiet_a: assert property (
    (cs == 3'b000) [*5] |-> !events.overflow && !events.match_a)
    else $error("event while stopped");
  cap_rise_a: assert property (
    cap_on && !ctb_reg[7] && ctb_reg[6] && $rose(capture_input_pin)
    |-> ##[1:6] events.capture) else $error("capture missed");
  cap_filt_a: assert property (
    cap_on && ctb_reg[7] && ctb_reg[6] && $rose(capture_input_pin)
    |-> (!events.capture) [*3] ##[1:10] events.capture)
    else $error("filtered capture timing");
  force_flip_a: assert property (
    frc_a ##0 (mode == 4'h0 && cta_reg[7:6] == 2'b01)
    |-> ##[1:3] $changed(compare_out_a)) else $error("force no toggle");
  force_quiet_a: assert property (
    frc_a |-> (!events.match_a) [*4]) else $error("force raised event");
  cnt_block_a: assert property (
    io_req.wr && io_req.addr == `OFS_CNT_L && cs == 3'b001
    |=> (!events.match_a) [*3]) else $error("match not blocked");
endmodule : timer16_monitor
bind timer16_mode_clock_capture_ctrl timer16_monitor timer16_monitor_i (
  .core_clk(core_clk), .arst_n(arst_n), .io_req(io_req),
  .io_rdata(io_rdata), .capture_input_pin(capture_input_pin),
  .compare_out_a(compare_out_a), .events(events));

// File: tb/io_core_model.sv
// core model: byte strobes at the falling clock edge
// assumes read data settle one cycle after the read edge
`timescale 1ns/10ps
module io_core_model (
  input wire logic core_clk,
  input wire logic [7:0] io_rdata,
  output timer16_pkg::io_req_type io_req
);
  import timer16_pkg::*;
  initial io_req = '0;
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_req.addr = a;
    io_req.wdata = d;
    io_req.wr = 1'b1;
    @(negedge core_clk);
    io_req.wr = 1'b0;
    // stale data would hide a strobe that is ignored
    io_req.wdata = ~d;
  endtask : put
  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    io_req.addr = a;
    io_req.rd = 1'b1;
    @(negedge core_clk);
    io_req.rd = 1'b0;
    @(negedge core_clk);
    d = io_rdata;
  endtask : get
  task automatic get16(input logic [5:0] a, output logic [15:0] d);
    get(a, d[7:0]);
    get(a + 6'h01, d[15:8]);
  endtask : get16
endmodule : io_core_model

// File: tb/testbench.sv
// bench: timer block, core model and reference register model
// assumes 10 MHz core clock, stimulus on the falling edge
`timescale 1ns/10ps
`include "timer16_params.svh"
module testbench;
  import timer16_pkg::*;
  logic core_clk, arst_n, cap_pin, ext_pin, out_a, out_b, seen;
  io_req_type io_req;
  logic [7:0] io_rdata, b;
  logic [15:0] v, x;
  timer_events_type events;
  logic [31:0] seed = 32'h0000_b597;
  int miscompares, samples_checked, cycles, tmp;
  int regs[64];
  int div[5] = '{1, 8, 64, 256, 1024};
  int md[8] = '{0, 5, 6, 7, 1, 4, 9, 15};
  logic [15:0] tp[8] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff,
                         16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
  timer16_mode_clock_capture_ctrl timer16_mode_clock_capture_ctrl_i (
    .core_clk(core_clk), .arst_n(arst_n), .io_req(io_req),
    .io_rdata(io_rdata), .capture_input_pin(cap_pin),
    .ext_count_pin(ext_pin), .compare_out_a(out_a),
    .compare_out_b(out_b), .events(events));
  io_core_model io_core_model_i (
    .core_clk(core_clk), .io_rdata(io_rdata), .io_req(io_req));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_core_model_i.put(a, d);
    case (a)
      `OFS_CTRL_A: regs[a] = d & 8'hf3;
      `OFS_CTRL_B: regs[a] = d & 8'hdf;
      `OFS_CAPT_H, `OFS_CMPB_H, `OFS_CMPA_H, `OFS_CNT_H: tmp = d;
      `OFS_CAPT_L, `OFS_CMPB_L, `OFS_CMPA_L, `OFS_CNT_L: begin
        regs[a] = d;
        regs[a + 1] = tmp;
      end
      default: ;
    endcase
  endtask : wr
  task automatic w16(input logic [5:0] a, input logic [15:0] d);
    wr(a + 6'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask : w16
  task automatic rd_all();
    for (int i = 'h22; i <= 'h2e; i++) begin
      io_core_model_i.get(i[5:0], b);
      chk($sformatf("reg %h", i), 16'(regs[i]), {8'h00, b});
    end
  endtask : rd_all
  // event bits: 3 overflow, 2 match a, 1 match b, 0 capture
  task automatic watch(input int n, input int s);
    seen = 1'b0;
    repeat (n) begin
      @(negedge core_clk);
      seen = seen | events[s];
    end
  endtask : watch
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    arst_n = 1'b0;
    cap_pin = 1'b0;
    ext_pin = 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    rd_all();
    for (int i = 'h22; i < 'h2a; i += 2) w16(i[5:0], {rnd(), rnd()});
    wr(`OFS_CTRL_A, rnd() & 8'hf3);
    wr(`OFS_CTRL_B, rnd() & 8'hd8);
    rd_all();
    wr(`OFS_CTRL_A, 8'h00);
    $display("done registers");
    for (int k = 0; k < 5; k++) begin
      w16(`OFS_CNT_L, 16'h0000);
      wr(`OFS_CTRL_B, 8'(k + 1));
      repeat (8 * div[k]) @(negedge core_clk);
      wr(`OFS_CTRL_B, 8'h00);
      io_core_model_i.get16(`OFS_CNT_L, v);
      chk("prescaled", 16'h0001, 16'(v >= 7 && v <= 11));
    end
    $display("done prescaler");
    // compare a at 0x00ff gives the variable-top modes an 8-bit top
    w16(`OFS_CMPA_L, 16'h00ff);
    for (int k = 0; k < 8; k++) begin
      wr(`OFS_CTRL_A, 8'(md[k] & 3));
      w16(`OFS_CNT_L, tp[k] - 16'h0003);
      wr(`OFS_CTRL_B, 8'(((md[k] >> 2) << 3) | 1));
      watch(20, 3);
      wr(`OFS_CTRL_B, 8'h00);
      io_core_model_i.get16(`OFS_CNT_L, v);
      x = 16'(md[k] % 8 != 1 && md[k] != 4);
      chk("overflow", x, 16'(seen));
      x = (md[k] % 8 == 1) ? 16'(v > tp[k] - 16'h0020 && v <= tp[k])
                           : 16'(v < 16'h0020);
      chk("top", 16'h0001, x);
    end
    wr(`OFS_CTRL_A, 8'h00);
    $display("done modes");
    for (int k = 7; k >= 6; k--) begin
      w16(`OFS_CNT_L, 16'h0000);
      wr(`OFS_CTRL_B, 8'(k));
      repeat (10) begin
        repeat (4) @(negedge core_clk);
        ext_pin = ~ext_pin;
      end
      repeat (6) @(negedge core_clk);
      wr(`OFS_CTRL_B, 8'h00);
      io_core_model_i.get16(`OFS_CNT_L, v);
      chk("pin edges", 16'h0005, v);
    end
    $display("done external");
    for (int k = 0; k < 4; k++) begin
      cap_pin = ~k[0];
      repeat (12) @(negedge core_clk);
      v = {rnd(), rnd()};
      w16(`OFS_CNT_L, v);
      wr(`OFS_CTRL_B, {k[1], k[0], 6'h00});
      cap_pin = k[0];
      watch(16, 0);
      chk("capture", 16'h0001, 16'(seen));
      io_core_model_i.get16(`OFS_CAPT_L, x);
      chk("captured", v, x);
    end
    wr(`OFS_CTRL_B, 8'h58);
    cap_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    cap_pin = 1'b1;
    watch(16, 0);
    chk("capture off", 16'h0000, 16'(seen));
    wr(`OFS_CTRL_B, 8'h00);
    $display("done capture");
    for (int k = 0; k < 2; k++) begin
      wr(`OFS_CTRL_A, 8'h40 >> (2 * k));
      b = {6'h00, out_b, out_a};
      wr(`OFS_FORCE, 8'h80 >> k);
      watch(4, 2 - k);
      chk("forced", 16'(b ^ (8'h01 << k)), {14'h0, out_b, out_a});
      chk("forced event", 16'h0000, 16'(seen));
    end
    wr(`OFS_CTRL_A, 8'h00);
    w16(`OFS_CMPA_L, 16'h0100);
    w16(`OFS_CNT_L, 16'h00f8);
    wr(`OFS_CTRL_B, 8'h01);
    watch(20, 2);
    chk("match", 16'h0001, 16'(seen));
    w16(`OFS_CNT_L, 16'h0100);
    watch(6, 2);
    chk("match blocked", 16'h0000, 16'(seen));
    $display("done compare");
    stop_test();
  end
endmodule : testbench
